// ==== inc/octcc_pkg.sv ====
// constants of the one channel timer channel control
package octcc_pkg;
   localparam logic [7:0] OCTCC_ADDR_SWEVT = 8'h14;
   localparam logic [7:0] OCTCC_ADDR_CHMODE = 8'h18;
   localparam logic [7:0] OCTCC_ADDR_CHENPOL = 8'h20;
   localparam logic [7:0] OCTCC_ADDR_COUNT = 8'h24;
   localparam logic [7:0] OCTCC_ADDR_DIV = 8'h28;
   localparam logic [7:0] OCTCC_ADDR_CMPVAL = 8'h34;
   localparam logic [7:0] OCTCC_ADDR_STATUS = 8'h10;
   localparam int OCTCC_BIT_UPG = 0;
   localparam int OCTCC_BIT_CHG = 1;
   localparam int OCTCC_BIT_EN = 0;
   localparam int OCTCC_BIT_MPOL = 1;
   localparam int OCTCC_BIT_CPOL = 3;
   localparam int OCTCC_BIT_FAST = 2;
   localparam int OCTCC_BIT_SHADOW = 3;
   localparam int OCTCC_BIT_FLAG = 1;
   localparam int OCTCC_BIT_OVER = 9;
   localparam logic [7:0] OCTCC_CHMODE_RESET = 8'h00;
   localparam logic [15:0] OCTCC_CMP_RESET = 16'h0000;
   localparam logic [1:0] OCTCC_MODE_OUT = 2'h0;
   localparam logic [1:0] OCTCC_MODE_IN = 2'h1;
   localparam logic [2:0] OCTCC_CMP_TIMING = 3'h0;
   localparam logic [2:0] OCTCC_CMP_SET = 3'h1;
   localparam logic [2:0] OCTCC_CMP_CLEAR = 3'h2;
   localparam logic [2:0] OCTCC_CMP_TOGGLE = 3'h3;
   localparam logic [2:0] OCTCC_CMP_FLOW = 3'h4;
   localparam logic [2:0] OCTCC_CMP_FHIGH = 3'h5;
   localparam logic [2:0] OCTCC_CMP_PWM0 = 3'h6;
   localparam logic [2:0] OCTCC_CMP_PWM1 = 3'h7;
endpackage

// ==== inc/octcc_filt_if.sv ====
// link between channel control and input filter
interface octcc_filt_if;
   logic [3:0] code;
   logic [1:0] dts_div;
   logic raw;
   logic filtered;
   modport ctrl (output code, output dts_div, output raw, input filtered);
   modport filt (input code, input dts_div, input raw, output filtered);
endinterface

// ==== core/octcc_filter.sv ====
// digital input filter for the channel input
module octcc_filter (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // control side
   octcc_filt_if.filt fif
);
   typedef struct packed {
      logic [9:0] div;
      logic [3:0] run;
      logic level;
   } octcc_filt_s;

   octcc_filt_s q;
   octcc_filt_s next_q;
   logic [9:0] period;
   logic [3:0] need;

   function automatic logic [9:0] octcc_per(input logic [3:0] sh);
      octcc_per = 10'(1) << sh;
   endfunction

   always_comb begin
      logic [1:0] d;
      d = (fif.dts_div == 2'h3) ? 2'h0 : fif.dts_div;
      period = 10'h001;
      need = 4'h1;
      unique case (fif.code)
         4'h0: need = 4'h1;
         4'h1: need = 4'h2;
         4'h2: need = 4'h4;
         4'h3: need = 4'h8;
         4'h4, 4'h6, 4'h8: need = 4'h6;
         4'h5, 4'h7, 4'h9, 4'hC, 4'hF: need = 4'h8;
         4'hA, 4'hD: need = 4'h5;
         4'hB, 4'hE: need = 4'h6;
      endcase
      if (fif.code >= 4'h4 && fif.code <= 4'h5)
         period = octcc_per(4'(d) + 4'h1);
      else if (fif.code <= 4'h7 && fif.code >= 4'h6)
         period = octcc_per(4'(d) + 4'h2);
      else if (fif.code <= 4'h9 && fif.code >= 4'h8)
         period = octcc_per(4'(d) + 4'h3);
      else if (fif.code >= 4'hA && fif.code <= 4'hC)
         period = octcc_per(4'(d) + 4'h4);
      else if (fif.code >= 4'hD)
         period = octcc_per(4'(d) + 4'h5);
      next_q = q;
      if (fif.code == 4'h0) begin
         next_q.level = fif.raw;
         next_q.run = 4'h0;
         next_q.div = 10'h000;
      end else if (q.div + 10'h001 >= period) begin
         next_q.div = 10'h000;
         if (fif.raw == q.level) begin
            next_q.run = 4'h0;
         end else if (q.run + 4'h1 >= need) begin
            next_q.level = fif.raw;
            next_q.run = 4'h0;
         end else begin
            next_q.run = q.run + 4'h1;
         end
      end else begin
         next_q.div = q.div + 10'h001;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign fif.filtered = q.level;
endmodule

// ==== core/octcc_top.sv ====
// channel control, counter and prescaler of the one channel timer
module octcc_top
   import octcc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // loose control and status
   input wire logic [1:0] protection_level_i,
   input wire logic [1:0] filter_sample_clock_i,
   input wire logic single_pulse_enable_i,
   input wire logic count_up_i,
   input wire logic trigger_i,
   input wire logic [15:0] reload_i,
   // channel pin
   input wire logic channel_pin_i,
   output logic channel_o,
   output logic channel_n_o,
   output logic channel_oe_o,
   // events
   output logic update_event_o,
   output logic channel_event_o
);
   import octcc_pkg::*;

   typedef struct packed {
      logic [7:0] chmode;
      logic mpol;
      logic cpol;
      logic en;
      logic [15:0] count;
      logic [15:0] div;
      logic [15:0] div_shadow;
      logic [15:0] div_cnt;
      logic [15:0] cmp;
      logic [15:0] cmp_shadow;
      logic prep;
      logic flag;
      logic over;
      logic [2:0] edges;
      logic filt_d;
      logic pin_s1;
      logic pin_s2;
      logic trig_d;
      logic [31:0] rdata;
      logic upd;
      logic chev;
   } octcc_state_s;

   octcc_state_s q;
   octcc_state_s next_q;
   octcc_filt_if fif ();

   ////////////////////////////////////////////////////////////////////
   // input filter
   octcc_filter u_filter (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .fif(fif)
   );

   function automatic logic octcc_hit(input logic [7:0] a, input logic [7:0] b,
                                      input logic s);
      octcc_hit = s && (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [2:0] mode;
      logic is_in;
      logic [15:0] cmp_eff;
      logic tick;
      logic upd;
      logic chg;
      logic fin;
      logic edge_ok;
      logic rise;
      logic fall;
      logic capture;
      logic match;
      logic pwm_lvl;
      logic [2:0] edge_need;
      edge_ok = 1'b0;
      pwm_lvl = 1'b0;
      edge_need = 3'h0;
      next_q = q;
      mode = q.chmode[6:4];
      is_in = (q.chmode[1:0] == OCTCC_MODE_IN);
      fif.code = is_in ? q.chmode[7:4] : 4'h0;
      fif.dts_div = filter_sample_clock_i;
      fif.raw = q.pin_s2;
      next_q.pin_s1 = channel_pin_i;
      next_q.pin_s2 = q.pin_s1;
      next_q.filt_d = fif.filtered;
      next_q.trig_d = trigger_i;
      upd = octcc_hit(addr_i, OCTCC_ADDR_SWEVT, wr_i)
            && wdata_i[OCTCC_BIT_UPG];
      chg = octcc_hit(addr_i, OCTCC_ADDR_SWEVT, wr_i)
            && wdata_i[OCTCC_BIT_CHG];
      // counter and prescaler
      tick = (q.div_cnt == q.div_shadow);
      next_q.div_cnt = tick ? 16'h0000 : q.div_cnt + 16'h0001;
      if (tick) begin
         next_q.count = (q.count == reload_i) ? 16'h0000
                        : q.count + 16'h0001;
         if (q.count == reload_i)
            upd = 1'b1;
      end
      if (upd) begin
         next_q.count = 16'h0000;
         next_q.div_cnt = 16'h0000;
         next_q.div_shadow = q.div;
         next_q.cmp_shadow = q.cmp;
      end
      if (octcc_hit(addr_i, OCTCC_ADDR_COUNT, wr_i))
         next_q.count = wdata_i[15:0];
      cmp_eff = q.chmode[OCTCC_BIT_SHADOW] ? q.cmp_shadow : q.cmp;
      // input edge detection
      fin = q.filt_d;
      rise = fif.filtered && !fin;
      fall = !fif.filtered && fin;
      unique case ({q.cpol, q.mpol})
         2'b00: edge_ok = rise;
         2'b01: edge_ok = fall;
         2'b11: edge_ok = rise || fall;
         default: edge_ok = 1'b0;
      endcase
      unique case (q.chmode[3:2])
         2'h0: edge_need = 3'h0;
         2'h1: edge_need = 3'h1;
         2'h2: edge_need = 3'h3;
         2'h3: edge_need = 3'h7;
      endcase
      capture = 1'b0;
      if (!q.en) begin
         next_q.edges = 3'h0;
      end else if (is_in && edge_ok) begin
         if (q.edges == edge_need) begin
            next_q.edges = 3'h0;
            capture = 1'b1;
         end else begin
            next_q.edges = q.edges + 3'h1;
         end
      end
      // compare output
      match = !is_in && (q.count == cmp_eff);
      if (count_up_i)
         pwm_lvl = (q.count < cmp_eff);
      else
         pwm_lvl = !(q.count > cmp_eff);
      if (!is_in) begin
         unique case (mode)
            OCTCC_CMP_TIMING: next_q.prep = q.prep;
            OCTCC_CMP_SET: if (match) next_q.prep = 1'b1;
            OCTCC_CMP_CLEAR: if (match) next_q.prep = 1'b0;
            OCTCC_CMP_TOGGLE: if (match) next_q.prep = !q.prep;
            OCTCC_CMP_FLOW: next_q.prep = 1'b0;
            OCTCC_CMP_FHIGH: next_q.prep = 1'b1;
            OCTCC_CMP_PWM0: next_q.prep = pwm_lvl;
            OCTCC_CMP_PWM1: next_q.prep = !pwm_lvl;
         endcase
         if (mode[2:1] == 2'b11 && q.chmode[OCTCC_BIT_FAST]
             && trigger_i && !q.trig_d)
            next_q.prep = (mode == OCTCC_CMP_PWM0) ? 1'b0 : 1'b1;
      end
      // flags
      if (chg || capture || (match && q.en && !single_pulse_enable_i)
          || (match && q.en)) begin
         next_q.flag = 1'b1;
         if (is_in) begin
            next_q.cmp = q.count;
            if (q.flag)
               next_q.over = 1'b1;
         end
      end
      if (octcc_hit(addr_i, OCTCC_ADDR_STATUS, wr_i)) begin
         if (!wdata_i[OCTCC_BIT_FLAG] && !next_q.flag)
            next_q.flag = 1'b0;
         if (!wdata_i[OCTCC_BIT_FLAG] && q.flag == next_q.flag
             && !(chg || capture || match))
            next_q.flag = 1'b0;
         if (!wdata_i[OCTCC_BIT_OVER] && !(is_in && q.flag
             && (chg || capture)))
            next_q.over = 1'b0;
      end
      next_q.upd = upd;
      next_q.chev = chg || capture || (match && q.en);
      // register writes
      if (octcc_hit(addr_i, OCTCC_ADDR_CHMODE, wr_i)) begin
         next_q.chmode[7:2] = wdata_i[7:2];
         if (!q.en)
            next_q.chmode[1:0] = wdata_i[1:0];
      end
      if (octcc_hit(addr_i, OCTCC_ADDR_CHENPOL, wr_i)) begin
         next_q.en = wdata_i[OCTCC_BIT_EN];
         if (!protection_level_i[1]) begin
            next_q.mpol = wdata_i[OCTCC_BIT_MPOL];
            next_q.cpol = wdata_i[OCTCC_BIT_CPOL];
         end
      end
      if (octcc_hit(addr_i, OCTCC_ADDR_DIV, wr_i))
         next_q.div = wdata_i[15:0];
      if (octcc_hit(addr_i, OCTCC_ADDR_CMPVAL, wr_i) && !is_in)
         next_q.cmp = wdata_i[15:0];
      // register reads
      next_q.rdata = 32'h00000000;
      if (rd_i) begin
         unique case (addr_i)
            OCTCC_ADDR_CHMODE: next_q.rdata[7:0] = is_in ? q.chmode
                               : {1'b0, q.chmode[6:0]};
            OCTCC_ADDR_CHENPOL: next_q.rdata[3:0] = {q.cpol, 1'b0,
                                                     q.mpol, q.en};
            OCTCC_ADDR_COUNT: next_q.rdata[15:0] = q.count;
            OCTCC_ADDR_DIV: next_q.rdata[15:0] = q.div;
            OCTCC_ADDR_CMPVAL: next_q.rdata[15:0] = q.cmp;
            OCTCC_ADDR_STATUS: begin
               next_q.rdata[OCTCC_BIT_FLAG] = q.flag;
               next_q.rdata[OCTCC_BIT_OVER] = q.over;
            end
            default: next_q.rdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign rdata_o = q.rdata;
   assign channel_o = q.en && (q.prep ^ q.mpol);
   assign channel_n_o = q.en && (!q.prep ^ q.cpol);
   assign channel_oe_o = q.en && (q.chmode[1:0] == OCTCC_MODE_OUT);
   assign update_event_o = q.upd;
   assign channel_event_o = q.chev;
endmodule

// ==== tb/octcc_checker.sv ====
// port assertions of the channel control
module octcc_checker
   import octcc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0] protection_level_i,
   // outputs
   input wire logic channel_o,
   input wire logic channel_n_o,
   input wire logic update_event_o,
   input wire logic channel_event_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   sequence s_rd(logic [7:0] a);
      rd_i && addr_i == a;
   endsequence
   sequence s_sw(int b);
      wr_i && addr_i == OCTCC_ADDR_SWEVT && wdata_i[b];
   endsequence
   sequence s_lk;
      rd_i && addr_i == OCTCC_ADDR_CHENPOL && protection_level_i[1];
   endsequence
   sequence s_off;
      s_rd(OCTCC_ADDR_CHENPOL) ##1 (rdata_o[0] == 1'b0 && !wr_i);
   endsequence
   ////////////////////////////////////////
   property p_upg;
      s_sw(0) |=> update_event_o;
   endproperty
   a_upg: assert property (p_upg) else $error("no update pulse");
   property p_chg;
      s_sw(1) |-> ##[1:2] channel_event_o;
   endproperty
   a_chg: assert property (p_chg) else $error("no channel pulse");
   property p_idle;
      !$past(rd_i) |-> rdata_o == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("stray read data");
   property p_swz;
      s_rd(OCTCC_ADDR_SWEVT) |=> rdata_o == 32'h0;
   endproperty
   a_swz: assert property (p_swz) else $error("event bits read");
   property p_cnt;
      rd_i && (addr_i == OCTCC_ADDR_COUNT || addr_i == OCTCC_ADDR_DIV)
         |=> rdata_o[31:16] == 16'h0;
   endproperty
   a_cnt: assert property (p_cnt) else $error("count upper bits");
   property p_pol;
      s_rd(OCTCC_ADDR_CHENPOL) |=> rdata_o[31:4] == 28'h0 && !rdata_o[2];
   endproperty
   a_pol: assert property (p_pol) else $error("reserved bits set");
   property p_lock;
      s_lk ##1 protection_level_i[1] ##1 s_lk
         |=> rdata_o[3:1] == $past(rdata_o[3:1], 2);
   endproperty
   a_lock: assert property (p_lock) else $error("locked bit moved");
   property p_off;
      s_off |-> (!channel_o && !channel_n_o) ##1 (!channel_o && !channel_n_o);
   endproperty
   a_off: assert property (p_off) else $error("disabled but driven");
endmodule

bind octcc_top octcc_checker chk (.clock_i, .rst_n_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .rdata_o, .protection_level_i, .channel_o, .channel_n_o,
   .update_event_o, .channel_event_o);

// ==== tb/octcc_pin_src.sv ====
// channel pin source: one pulse per request toggle
module octcc_pin_src (
   // request side
   input wire logic req_i,
   input wire logic [7:0] width_i,
   // channel pin
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial pin_o = 1'b0;
   always @(req_i) begin
      #3.3 pin_o = 1'b1;
      #(width_i) pin_o = 1'b0;
   end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench of the channel control
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import octcc_pkg::*;
   logic clock_i, rst_n_i, wr_i, rd_i, req, pin, ch_o, chn_o, oe_o;
   logic [7:0] addr_i, width;
   logic [31:0] wdata_i, rdata_o, rd_v;
   logic [1:0] protection_level;
   int failures, compares;
   octcc_top uut (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .protection_level_i(protection_level), .filter_sample_clock_i(2'h0),
      .single_pulse_enable_i(1'b0), .count_up_i(1'b1), .trigger_i(1'b0),
      .reload_i(16'h0009), .channel_pin_i(pin), .channel_o(ch_o),
      .channel_n_o(chn_o), .channel_oe_o(oe_o), .update_event_o(),
      .channel_event_o());
   octcc_pin_src src (.req_i(req), .width_i(width), .pin_o(pin));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   ////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
      @(posedge clock_i);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a, rd_v);
      chk(rd_v, e);
   endtask
   task flag(input logic [31:0] e);
      rd(OCTCC_ADDR_STATUS, rd_v);
      chk(rd_v & 32'h202, e);
   endtask
   task mode(input logic [2:0] c);
      wr(OCTCC_ADDR_CHMODE, {25'h0, c, 4'h0});
      cyc(12);
   endtask
   task lvl(input logic [1:0] e);
      cyc(3);
      #1 chk({30'h0, ch_o, chn_o}, {30'h0, e});
   endtask
   task ones(input logic [31:0] e);
      int n;
      n = 0;
      repeat (10) begin
         @(posedge clock_i);
         #1 n += int'(ch_o === 1'b1);
      end
      chk(32'(n), e);
   endtask
   task pulse(input logic [7:0] w);
      width <= w;
      req <= ~req;
      cyc(60);
   endtask
   ////////////////////////////////////////
   task t_regs;
      rdc(OCTCC_ADDR_CHMODE, 32'h0);
      rdc(OCTCC_ADDR_CHENPOL, 32'h0);
      rdc(OCTCC_ADDR_DIV, 32'h0);
      rdc(OCTCC_ADDR_SWEVT, 32'h0);
      rdc(8'h40, 32'h0);
      wr(OCTCC_ADDR_CHENPOL, 32'hFFFFFFF4);
      rdc(OCTCC_ADDR_CHENPOL, 32'h0);
      $display("test regs done");
   endtask
   task t_count;
      logic [31:0] a;
      rd(OCTCC_ADDR_COUNT, a);
      rd(OCTCC_ADDR_COUNT, rd_v);
      chk({31'h0, a == rd_v}, 32'h0);
      wr(OCTCC_ADDR_DIV, 32'h0000FFFF);
      wr(OCTCC_ADDR_SWEVT, 32'h1);
      rdc(OCTCC_ADDR_COUNT, 32'h0);
      cyc(20);
      rdc(OCTCC_ADDR_COUNT, 32'h0);
      wr(OCTCC_ADDR_COUNT, 32'h00001234);
      rdc(OCTCC_ADDR_COUNT, 32'h00001234);
      rdc(OCTCC_ADDR_DIV, 32'h0000FFFF);
      wr(OCTCC_ADDR_DIV, 32'h0);
      wr(OCTCC_ADDR_SWEVT, 32'h1);
      $display("test count done");
   endtask
   task t_lock;
      protection_level <= 2'b10;
      wr(OCTCC_ADDR_CHENPOL, 32'hB);
      rdc(OCTCC_ADDR_CHENPOL, 32'h1);
      rdc(OCTCC_ADDR_CHENPOL, 32'h1);
      protection_level <= 2'b11;
      wr(OCTCC_ADDR_CHENPOL, 32'h3);
      rdc(OCTCC_ADDR_CHENPOL, 32'h1);
      protection_level <= 2'b00;
      wr(OCTCC_ADDR_CHMODE, 32'h1);
      rdc(OCTCC_ADDR_CHMODE, 32'h0);
      $display("test lock done");
   endtask
   task t_out;
      logic v;
      wr(OCTCC_ADDR_CMPVAL, 32'h3);
      mode(OCTCC_CMP_FHIGH);
      lvl(2'b10);
      chk({31'h0, oe_o}, 32'h1);
      wr(OCTCC_ADDR_CHENPOL, 32'hB);
      lvl(2'b01);
      wr(OCTCC_ADDR_CHENPOL, 32'h1);
      mode(OCTCC_CMP_TIMING);
      ones(32'd10);
      mode(OCTCC_CMP_FLOW);
      lvl(2'b01);
      mode(OCTCC_CMP_TIMING);
      ones(32'd0);
      mode(OCTCC_CMP_SET);
      lvl(2'b10);
      mode(OCTCC_CMP_CLEAR);
      lvl(2'b01);
      mode(OCTCC_CMP_TOGGLE);
      #1 v = ch_o;
      cyc(10);
      #1 chk({31'h0, ch_o}, {31'h0, ~v});
      mode(OCTCC_CMP_PWM0);
      ones(32'd3);
      mode(OCTCC_CMP_PWM1);
      ones(32'd7);
      wr(OCTCC_ADDR_CHMODE, 32'h68);
      wr(OCTCC_ADDR_DIV, 32'h0000FFFF);
      wr(OCTCC_ADDR_SWEVT, 32'h1);
      wr(OCTCC_ADDR_COUNT, 32'h4);
      wr(OCTCC_ADDR_CMPVAL, 32'h5);
      ones(32'd0);
      wr(OCTCC_ADDR_SWEVT, 32'h1);
      ones(32'd10);
      wr(OCTCC_ADDR_DIV, 32'h0);
      wr(OCTCC_ADDR_SWEVT, 32'h1);
      $display("test compare done");
   endtask
   task t_cap;
      wr(OCTCC_ADDR_CHENPOL, 32'h0);
      wr(OCTCC_ADDR_CHMODE, 32'h5);
      wr(OCTCC_ADDR_CHENPOL, 32'h1);
      chk({31'h0, oe_o}, 32'h0);
      wr(OCTCC_ADDR_STATUS, 32'h0);
      pulse(8'd60);
      flag(32'h0);
      pulse(8'd60);
      flag(32'h2);
      wr(OCTCC_ADDR_SWEVT, 32'h2);
      flag(32'h202);
      wr(OCTCC_ADDR_STATUS, 32'h0);
      pulse(8'd60);
      wr(OCTCC_ADDR_CHENPOL, 32'h0);
      wr(OCTCC_ADDR_CHENPOL, 32'h1);
      pulse(8'd60);
      flag(32'h0);
      wr(OCTCC_ADDR_CHENPOL, 32'h0);
      wr(OCTCC_ADDR_CHENPOL, 32'hB);
      pulse(8'd60);
      flag(32'h2);
      wr(OCTCC_ADDR_CHENPOL, 32'h0);
      wr(OCTCC_ADDR_CHMODE, 32'h31);
      wr(OCTCC_ADDR_CHENPOL, 32'h1);
      wr(OCTCC_ADDR_STATUS, 32'h0);
      pulse(8'd20);
      flag(32'h0);
      pulse(8'd100);
      flag(32'h2);
      $display("test capture done");
   endtask
   task results;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #100000;
      failures++;
      results;
   end
   initial begin
      rst_n_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      protection_level = 2'h0;
      req = 1'b0;
      width = 8'd60;
      failures = 0;
      compares = 0;
      cyc(16);
      rst_n_i <= 1'b1;
      cyc(1);
      t_regs;
      t_count;
      t_lock;
      t_out;
      t_cap;
      results;
   end
endmodule
